// ### rtl/sync_2ff.sv
// Two-flop synchroniser for levels arriving from pins or the slow clock.
// Assumes the input is a level that holds for several system clocks.
`timescale 1ns/1ps
module sync_2ff #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : sync_2ff

// ### rtl/touch_detector.sv
// Charge-share touch detector control: registers, modulation clock,
// discharge/scan sequencing, 12-bit duty counter, flags and pad control.
// Assumes sys_clk_i is the fast system clock; the slow clock, comparator and
// Schmitt outputs arrive asynchronously from the analog side.
`timescale 1ns/1ps
module touch_detector (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [9:0] addr_i,
	input wire logic [3:0] wdata_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic slow_clk_i,
	input wire logic schmitt_i,
	input wire logic comp_i,
	output logic [3:0] rdata_o,
	output logic [2:0] pad_switch_o,
	output logic [2:0] pad_hiz_o,
	output logic [2:0] pad_pullup_off_o,
	output logic [2:0] pad_wakeup_off_o,
	output logic detector_enable_o,
	output logic sensor_gate_o,
	output logic cap_tie_vss_o,
	output logic cap_tie_vdd_o,
	output logic use_comparator_o,
	output logic [1:0] ref_level_sel_o,
	output logic overflow_irq_o,
	output logic overcharge_irq_o
);
	logic [1:0] irq_en_q;
	logic flag_ovf_q;
	logic flag_ovc_q;
	logic [2:0] seq_code_q;
	logic [2:0] mod_code_q;
	logic [3:0] analog_cfg_q;
	logic [2:0] chan_en_q;
	logic [2:0] run_code_q;
	logic [11:0] reload_q;
	logic [11:0] count_q;
	logic [5:0] prescale_q;
	logic slow_prev_q;
	logic mod_tick;
	logic [5:0] div_mask;
	logic [2:0] in_sync;
	logic sense_level;
	logic [3:0] disch_cnt_q;
	logic [2:0] miss_cnt_q;
	logic [4:0] seq_cnt_q;
	logic charge_phase_q;
	touch_pkg::scan_state_t state_q;
	logic wr_chan, wr_run, start, inc, ovf_evt, ovc_evt;

	// Write decode; any non-stop run code raises start, as does a channel write; hold goes to ST_HOLD, not discharge
	assign wr_chan = wr_en_i && (addr_i == touch_pkg::ADDR_CHAN_SEL);
	assign wr_run = wr_en_i && (addr_i == touch_pkg::ADDR_RUN_CTRL);
	assign start = wr_chan || (wr_run && wdata_i[2:0] != touch_pkg::RUN_STOP);

	// Analog side and slow clock are asynchronous
	sync_2ff #(
		.WIDTH(3)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({slow_clk_i, comp_i, schmitt_i}),
		.sync_o(in_sync)
	);

	// Sensing signal choice
	assign sense_level = analog_cfg_q[touch_pkg::DETECT_TYPE_BIT] ? in_sync[1] : in_sync[0];

	// Modulation tick: prefix of the free prescaler, or slow clock edge
	assign div_mask = 6'((7'h01 << mod_code_q) - 7'h01);
	always_comb
	begin
		if (mod_code_q == touch_pkg::MOD_CODE_SLOW)
			mod_tick = in_sync[2] && !slow_prev_q;
		else
			mod_tick = ((prescale_q & div_mask) == div_mask);
	end

	// Free-running prescaler and slow edge history
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			prescale_q <= 6'h00;
			slow_prev_q <= 1'b0;
		end
		else
		begin
			prescale_q <= prescale_q + 6'h01;
			slow_prev_q <= in_sync[2];
		end
	end

	// Counting and period-end events
	assign inc = (state_q == touch_pkg::ST_SCAN) && mod_tick && sense_level;
	assign ovf_evt = inc && (count_q == touch_pkg::COUNT_ALL_ONES);
	assign ovc_evt = (state_q == touch_pkg::ST_SCAN) && mod_tick && !sense_level
		&& (miss_cnt_q == touch_pkg::OVERCHARGE_DEBOUNCE - 3'h1);

	// Configuration registers written by software
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			irq_en_q <= 2'h0;
			seq_code_q <= touch_pkg::SEQ_OFF;
			mod_code_q <= touch_pkg::MOD_CLK_RESET;
			analog_cfg_q <= 4'h0;
			chan_en_q <= 3'h0;
		end
		else if (wr_en_i)
		begin
			if (addr_i == touch_pkg::ADDR_IRQ_ENABLE)
				irq_en_q <= {wdata_i[touch_pkg::OVF_BIT], wdata_i[touch_pkg::OVC_BIT]};
			else if (addr_i == touch_pkg::ADDR_SEQ_CTRL)
				seq_code_q <= wdata_i[3:touch_pkg::SEQ_LSB];
			else if (addr_i == touch_pkg::ADDR_MOD_CLK_SEL)
				mod_code_q <= wdata_i[2:0];
			else if (addr_i == touch_pkg::ADDR_ANALOG_CFG)
				analog_cfg_q <= wdata_i;
			else if (addr_i == touch_pkg::ADDR_CHAN_SEL)
				chan_en_q <= wdata_i[2:0];
		end
	end

	// Run code: a channel write forces run
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			run_code_q <= touch_pkg::RUN_STOP;
		else if (wr_chan)
			run_code_q <= touch_pkg::RUN_SCAN;
		else if (wr_run)
			run_code_q <= wdata_i[2:0];
	end

	// Reload latch: nibble writes never touch the live counter
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			reload_q <= touch_pkg::COUNT_RESET;
		else if (wr_en_i)
		begin
			if (addr_i == touch_pkg::ADDR_COUNT_LOW)
				reload_q[3:0] <= wdata_i;
			else if (addr_i == touch_pkg::ADDR_COUNT_MID)
				reload_q[7:4] <= wdata_i;
			else if (addr_i == touch_pkg::ADDR_COUNT_HIGH)
				reload_q[11:8] <= wdata_i;
		end
	end

	// Duty counter: preload with complement so the count runs to overflow
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			count_q <= touch_pkg::COUNT_RESET;
		else if (start)
			count_q <= ~reload_q;
		else if (inc)
			count_q <= count_q + 12'h001;
	end

	// Flags: a hardware set beats a same-cycle clear
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			flag_ovf_q <= 1'b0;
			flag_ovc_q <= 1'b0;
		end
		else
		begin
			if (ovf_evt)
				flag_ovf_q <= 1'b1;
			else if (start)
				flag_ovf_q <= 1'b0;
			else if (wr_en_i && addr_i == touch_pkg::ADDR_IRQ_FLAGS)
				flag_ovf_q <= wdata_i[touch_pkg::OVF_BIT];
			if (ovc_evt)
				flag_ovc_q <= 1'b1;
			else if (start)
				flag_ovc_q <= 1'b0;
			else if (wr_en_i && addr_i == touch_pkg::ADDR_IRQ_FLAGS)
				flag_ovc_q <= wdata_i[touch_pkg::OVC_BIT];
		end
	end

	// Scan sequencer: discharge first, then gate the sensor clock to period end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_q <= touch_pkg::ST_IDLE;
			disch_cnt_q <= 4'h0;
		end
		else if (wr_run && wdata_i[2:0] == touch_pkg::RUN_STOP)
			state_q <= touch_pkg::ST_IDLE;
		else if (wr_run && wdata_i[2:0] == touch_pkg::RUN_HOLD)
			state_q <= touch_pkg::ST_HOLD;
		else if (start)
		begin
			state_q <= touch_pkg::ST_DISCH;
			disch_cnt_q <= touch_pkg::DISCHARGE_LOAD;
		end
		else
		begin
			case (state_q)
				touch_pkg::ST_DISCH:
				begin
					if (disch_cnt_q == 4'h0)
						state_q <= touch_pkg::ST_SCAN;
					else
						disch_cnt_q <= disch_cnt_q - 4'h1;
				end
				touch_pkg::ST_SCAN:
				begin
					if (ovf_evt || ovc_evt)
						state_q <= touch_pkg::ST_DONE;
				end
				default:
					state_q <= state_q;
			endcase
		end
	end

	// Missed-tick debounce for overcharge; any counted tick resets it
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			miss_cnt_q <= 3'h0;
		else if (state_q != touch_pkg::ST_SCAN || inc)
			miss_cnt_q <= 3'h0;
		else if (mod_tick)
			miss_cnt_q <= miss_cnt_q + 3'h1;
	end

	// Charge/discharge sequence phase during a scan
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			seq_cnt_q <= 5'h00;
			charge_phase_q <= 1'b0;
		end
		else if (state_q != touch_pkg::ST_SCAN || touch_pkg::seq_period(seq_code_q) == 5'h00)
		begin
			seq_cnt_q <= 5'h00;
			charge_phase_q <= 1'b0;
		end
		else if (seq_cnt_q == touch_pkg::seq_period(seq_code_q) - 5'h01)
		begin
			seq_cnt_q <= 5'h00;
			charge_phase_q <= !charge_phase_q;
		end
		else
			seq_cnt_q <= seq_cnt_q + 5'h01;
	end

	// Pad and analog outputs; stop hands the pads back to the IO port
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pad_switch_o <= 3'h0;
			pad_hiz_o <= 3'h0;
			pad_pullup_off_o <= 3'h0;
			pad_wakeup_off_o <= 3'h0;
			detector_enable_o <= 1'b0;
			sensor_gate_o <= 1'b0;
			cap_tie_vss_o <= 1'b0;
			cap_tie_vdd_o <= 1'b0;
		end
		else
		begin
			if (state_q == touch_pkg::ST_DISCH || state_q == touch_pkg::ST_SCAN
				|| state_q == touch_pkg::ST_HOLD)
			begin
				pad_switch_o <= chan_en_q;
				pad_hiz_o <= chan_en_q;
			end
			else
			begin
				pad_switch_o <= 3'h0;
				pad_hiz_o <= 3'h0;
			end
			if (run_code_q == touch_pkg::RUN_STOP)
			begin
				pad_pullup_off_o <= 3'h0;
				pad_wakeup_off_o <= 3'h0;
			end
			else
			begin
				pad_pullup_off_o <= chan_en_q;
				pad_wakeup_off_o <= chan_en_q;
			end
			detector_enable_o <= (run_code_q != touch_pkg::RUN_STOP);
			sensor_gate_o <= (state_q == touch_pkg::ST_SCAN);
			// Hold and sequencing follow the tie mode; discharge is always low
			cap_tie_vss_o <= (state_q == touch_pkg::ST_DISCH)
				|| ((state_q == touch_pkg::ST_HOLD || charge_phase_q)
				&& !analog_cfg_q[touch_pkg::TIE_MODE_BIT]);
			cap_tie_vdd_o <= (state_q == touch_pkg::ST_HOLD || charge_phase_q)
				&& analog_cfg_q[touch_pkg::TIE_MODE_BIT];
		end
	end

	// Reference and detect type out; codes 10 and 11 both mean one third
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ref_level_sel_o <= touch_pkg::REF_HALF;
			use_comparator_o <= 1'b0;
		end
		else
		begin
			if (analog_cfg_q[touch_pkg::REF_LSB + 1])
				ref_level_sel_o <= touch_pkg::REF_ONE_THIRD;
			else if (analog_cfg_q[touch_pkg::REF_LSB])
				ref_level_sel_o <= touch_pkg::REF_TWO_THIRDS;
			else
				ref_level_sel_o <= touch_pkg::REF_HALF;
			use_comparator_o <= analog_cfg_q[touch_pkg::DETECT_TYPE_BIT];
		end
	end

	// Interrupt requests: flag gated by its enable
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			overflow_irq_o <= 1'b0;
			overcharge_irq_o <= 1'b0;
		end
		else
		begin
			overflow_irq_o <= flag_ovf_q && irq_en_q[1];
			overcharge_irq_o <= flag_ovc_q && irq_en_q[0];
		end
	end

	// Read port; unmapped addresses read zero
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rdata_o <= 4'h0;
		else if (!rd_en_i)
			rdata_o <= 4'h0;
		else if (addr_i == touch_pkg::ADDR_IRQ_ENABLE)
			rdata_o <= {irq_en_q, 2'h0};
		else if (addr_i == touch_pkg::ADDR_IRQ_FLAGS)
			rdata_o <= {flag_ovf_q, flag_ovc_q, 2'h0};
		else if (addr_i == touch_pkg::ADDR_SEQ_CTRL)
			rdata_o <= {seq_code_q, 1'b0};
		else if (addr_i == touch_pkg::ADDR_MOD_CLK_SEL)
			rdata_o <= {1'b0, mod_code_q};
		else if (addr_i == touch_pkg::ADDR_ANALOG_CFG)
			rdata_o <= analog_cfg_q;
		else if (addr_i == touch_pkg::ADDR_CHAN_SEL)
			rdata_o <= {1'b0, chan_en_q};
		else if (addr_i == touch_pkg::ADDR_RUN_CTRL)
			rdata_o <= {1'b0, run_code_q};
		else if (addr_i == touch_pkg::ADDR_COUNT_LOW)
			rdata_o <= count_q[3:0];
		else if (addr_i == touch_pkg::ADDR_COUNT_MID)
			rdata_o <= count_q[7:4];
		else if (addr_i == touch_pkg::ADDR_COUNT_HIGH)
			rdata_o <= count_q[11:8];
		else
			rdata_o <= 4'h0;
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	property p_preload;
		start |=> count_q == ~$past(reload_q);
	endproperty
	a_preload: assert property (p_preload) else $error("counter not preloaded");

	property p_clear_flags;
		wr_chan && !ovf_evt && !ovc_evt |=> !flag_ovf_q && !flag_ovc_q;
	endproperty
	a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared");

	property p_force_run;
		wr_chan |=> run_code_q == touch_pkg::RUN_SCAN;
	endproperty
	a_force_run: assert property (p_force_run) else $error("run not forced");

	property p_discharge_first;
		wr_chan && !wr_run |=> state_q == touch_pkg::ST_DISCH ##1 cap_tie_vss_o && !sensor_gate_o;
	endproperty
	a_discharge_first: assert property (p_discharge_first) else $error("no discharge");

	property p_latch_only;
		wr_en_i && addr_i == touch_pkg::ADDR_COUNT_LOW && !start && !inc |=> $stable(count_q);
	endproperty
	a_latch_only: assert property (p_latch_only) else $error("write hit counter");

	property p_count_up;
		inc && !start && count_q != touch_pkg::COUNT_ALL_ONES |=> count_q == $past(count_q) + 12'h001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("count step wrong");

	property p_overflow_flag;
		ovf_evt |=> flag_ovf_q && count_q == 12'h000 ##1 state_q == touch_pkg::ST_DONE;
	endproperty
	a_overflow_flag: assert property (p_overflow_flag) else $error("overflow lost");

	property p_hiz_follows;
		pad_switch_o == pad_hiz_o;
	endproperty
	a_hiz_follows: assert property (p_hiz_follows) else $error("pad not tri-stated");

	property p_stop_release;
		run_code_q == touch_pkg::RUN_STOP |=> pad_pullup_off_o == 3'h0 && !detector_enable_o;
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("pads kept in stop");

	property p_irq_gate;
		flag_ovc_q && irq_en_q[0] |=> overcharge_irq_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("overcharge irq missing");

	property p_live_read;
		rd_en_i && addr_i == touch_pkg::ADDR_COUNT_HIGH |=> rdata_o == $past(count_q[11:8]);
	endproperty
	a_live_read: assert property (p_live_read) else $error("count read wrong");

	c_overflow: cover property (ovf_evt);
	c_overcharge: cover property (ovc_evt);
	c_hold: cover property (state_q == touch_pkg::ST_HOLD && cap_tie_vdd_o);
	c_sequence: cover property (charge_phase_q && state_q == touch_pkg::ST_SCAN);
endmodule : touch_detector

// ### rtl/touch_pkg.sv
// Package for the charge-share touch detector: register map, field layout,
// codes, reset values and timing constants. Used by rtl/touch_detector.sv.
package touch_pkg;
	// Register offsets on the nibble register port
	localparam logic [9:0] ADDR_IRQ_ENABLE = 10'h00e;
	localparam logic [9:0] ADDR_IRQ_FLAGS = 10'h00f;
	localparam logic [9:0] ADDR_SEQ_CTRL = 10'h20d;
	localparam logic [9:0] ADDR_MOD_CLK_SEL = 10'h240;
	localparam logic [9:0] ADDR_ANALOG_CFG = 10'h241;
	localparam logic [9:0] ADDR_CHAN_SEL = 10'h243;
	localparam logic [9:0] ADDR_RUN_CTRL = 10'h248;
	localparam logic [9:0] ADDR_COUNT_LOW = 10'h249;
	localparam logic [9:0] ADDR_COUNT_MID = 10'h24a;
	localparam logic [9:0] ADDR_COUNT_HIGH = 10'h24b;

	// Field positions
	localparam int OVF_BIT = 3;
	localparam int OVC_BIT = 2;
	localparam int TIE_MODE_BIT = 0;
	localparam int DETECT_TYPE_BIT = 1;
	localparam int REF_LSB = 2;
	localparam int SEQ_LSB = 1;

	// Reset values
	localparam logic [2:0] MOD_CLK_RESET = 3'h7;
	localparam logic [11:0] COUNT_RESET = 12'hfff;
	localparam logic [11:0] COUNT_ALL_ONES = 12'hfff;

	// Codes
	localparam logic [2:0] MOD_CODE_SLOW = 3'h7;
	localparam logic [2:0] RUN_STOP = 3'h0;
	localparam logic [2:0] RUN_SCAN = 3'h1;
	localparam logic [2:0] RUN_HOLD = 3'h3;
	localparam logic [2:0] SEQ_OFF = 3'h0;
	localparam logic [1:0] REF_HALF = 2'h0;
	localparam logic [1:0] REF_TWO_THIRDS = 2'h1;
	localparam logic [1:0] REF_ONE_THIRD = 2'h2;

	// Sequence change periods in clocks, codes 1 to 6
	localparam logic [4:0] SEQ_P1 = 5'h02;
	localparam logic [4:0] SEQ_P2 = 5'h04;
	localparam logic [4:0] SEQ_P3 = 5'h06;
	localparam logic [4:0] SEQ_P4 = 5'h08;
	localparam logic [4:0] SEQ_P5 = 5'h0c;
	localparam logic [4:0] SEQ_P6 = 5'h10;

	// Timing
	localparam int CLK_MHZ = 40;
	localparam int DISCHARGE_TIME_NS = 200;
	localparam int DISCHARGE_CYCLES = (DISCHARGE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] DISCHARGE_LOAD = 4'(DISCHARGE_CYCLES - 1);
	localparam logic [2:0] OVERCHARGE_DEBOUNCE = 3'h4;

	typedef enum logic [2:0] {ST_IDLE, ST_DISCH, ST_SCAN, ST_DONE, ST_HOLD} scan_state_t;

	// Clocks per sequence phase; zero for off or reserved
	function automatic logic [4:0] seq_period(input logic [2:0] code);
		case (code)
			3'h1: seq_period = SEQ_P1;
			3'h2: seq_period = SEQ_P2;
			3'h3: seq_period = SEQ_P3;
			3'h4: seq_period = SEQ_P4;
			3'h5: seq_period = SEQ_P5;
			3'h6: seq_period = SEQ_P6;
			default: seq_period = 5'h00;
		endcase
	endfunction : seq_period
endpackage : touch_pkg

// ### verif/touch_pad_charge_share_detector_tb_top.sv
// Bench for the touch detector: register-port tasks, pad model, scan checks.
// Assumes the nibble register port with read data one cycle after the strobe.
`timescale 1ns/1ps
module touch_pad_charge_share_detector_tb_top;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [9:0] addr_i = 10'h000;
	logic [3:0] wdata_i = 4'h0;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic slow_clk_i = 1'b0;
	logic schmitt_i;
	logic comp_i;
	logic schmitt_lvl = 1'b1;
	logic comp_lvl = 1'b0;
	logic [3:0] rdata_o;
	logic [2:0] pad_switch_o, pad_hiz_o, pad_pullup_off_o, pad_wakeup_off_o;
	logic detector_enable_o, sensor_gate_o, cap_tie_vss_o, cap_tie_vdd_o, use_comparator_o;
	logic [1:0] ref_level_sel_o;
	logic overflow_irq_o, overcharge_irq_o;
	logic [3:0] rd_q;
	logic prev;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	int gate_seen = 0;
	int n, p, t;
	int per [8] = '{0, 2, 4, 6, 8, 12, 16, 0};
	logic [9:0] regs [11] = '{10'h00e, 10'h00f, 10'h20d, 10'h240, 10'h241, 10'h243,
		10'h248, 10'h249, 10'h24a, 10'h24b, 10'h100};
	logic [3:0] rstv [11] = '{4'h0, 4'h0, 4'h0, 4'h7, 4'h0, 4'h0, 4'h0, 4'hf, 4'hf, 4'hf, 4'h0};

	always #12.5 sys_clk_i = ~sys_clk_i;
	// Slow clock at 20 system clocks a period, far faster than real to keep runs short
	always
	begin
		repeat (10) @(posedge sys_clk_i);
		slow_clk_i <= ~slow_clk_i;
	end

	touch_detector DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .slow_clk_i(slow_clk_i),
		.schmitt_i(schmitt_i), .comp_i(comp_i), .rdata_o(rdata_o),
		.pad_switch_o(pad_switch_o), .pad_hiz_o(pad_hiz_o),
		.pad_pullup_off_o(pad_pullup_off_o), .pad_wakeup_off_o(pad_wakeup_off_o),
		.detector_enable_o(detector_enable_o), .sensor_gate_o(sensor_gate_o),
		.cap_tie_vss_o(cap_tie_vss_o), .cap_tie_vdd_o(cap_tie_vdd_o),
		.use_comparator_o(use_comparator_o), .ref_level_sel_o(ref_level_sel_o),
		.overflow_irq_o(overflow_irq_o), .overcharge_irq_o(overcharge_irq_o));

	touch_pad_far_side far_side (.sys_clk_i(sys_clk_i), .pad_switch_i(pad_switch_o),
		.schmitt_level_i(schmitt_lvl), .comp_level_i(comp_lvl), .schmitt_o(schmitt_i),
		.comp_o(comp_i));

	// Hang guard and a sticky note of the sensor gate opening
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (sensor_gate_o === 1'b1)
			gate_seen = 1;
		if (cycles == 20000)
		begin
			fails++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("Compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [9:0] a, input logic [3:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_en_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_en_i <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [9:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_en_i <= 1'b0;
		#1;
		rd_q = rdata_o;
	endtask : rd

	// Outputs are registered one edge behind the state they follow
	task automatic settle;
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask : settle

	// Cycles until an interrupt line rises; settles first so stale flags drop
	task automatic run_until(input logic ovf);
		settle();
		n = 0;
		while (((ovf ? overflow_irq_o : overcharge_irq_o) !== 1'b1) && n < 3000)
		begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
	endtask : run_until

	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		wr(10'h100, 4'h5);
		for (int i = 0; i < 11; i++)
		begin
			rd(regs[i]);
			check(rd_q, rstv[i]);
		end
		// Reference selector decode, comparator path flag
		for (int i = 0; i < 4; i++)
		begin
			wr(10'h241, {i[1:0], 2'h2});
			settle();
			check(ref_level_sel_o, (i == 3) ? 2'h2 : i[1:0]);
			check(use_comparator_o, 1'b1);
		end
		wr(10'h241, 4'h0);
		wr(10'h00e, 4'hc);
		wr(10'h00f, 4'h8);
		settle();
		check(overflow_irq_o, 1'b1);
		wr(10'h00f, 4'h0);
		// Reload latch writes leave the counter alone
		wr(10'h249, 4'hf);
		wr(10'h24a, 4'h0);
		wr(10'h24b, 4'h0);
		rd(10'h24a);
		check(rd_q, 4'hf);
		wr(10'h240, 4'h0);
		wr(10'h243, 4'h1);
		settle();
		check(pad_switch_o, 3'h1);
		check(pad_hiz_o, 3'h1);
		check({pad_pullup_off_o, pad_wakeup_off_o}, 6'h09);
		check({detector_enable_o, cap_tie_vss_o, sensor_gate_o}, 3'h6);
		rd(10'h249);
		check(rd_q, 4'h0);
		rd(10'h248);
		check(rd_q, 4'h1);
		run_until(1'b1);
		check(n < 60, 1'b1);
		check(gate_seen, 1);
		rd(10'h24b);
		check(rd_q, 4'h0);
		rd(10'h00f);
		check(rd_q, 4'h8);
		// Two pads on the comparator path with a low comparator
		wr(10'h241, 4'h2);
		wr(10'h243, 4'h6);
		settle();
		check(pad_switch_o, 3'h6);
		check(pad_hiz_o, 3'h6);
		rd(10'h00f);
		check(rd_q, 4'h0);
		run_until(1'b0);
		check(n < 60, 1'b1);
		rd(10'h00f);
		check(rd_q, 4'h4);
		// Stop releases pads but keeps flags; hold reloads and clears
		wr(10'h248, 4'h0);
		settle();
		check({detector_enable_o, pad_switch_o, pad_pullup_off_o}, 7'h00);
		rd(10'h00f);
		check(rd_q, 4'h4);
		wr(10'h241, 4'h0);
		wr(10'h249, 4'h5);
		wr(10'h248, 4'h3);
		repeat (40) @(posedge sys_clk_i);
		#1;
		check({pad_switch_o, sensor_gate_o, cap_tie_vss_o}, 5'h19);
		rd(10'h249);
		check(rd_q, 4'ha);
		rd(10'h00f);
		check(rd_q, 4'h0);
		wr(10'h241, 4'h1);
		settle();
		check(cap_tie_vdd_o, 1'b1);
		wr(10'h248, 4'h0);
		wr(10'h241, 4'h0);
		wr(10'h249, 4'hf);
		// Every modulation divider code, slow clock last
		for (int c = 0; c < 8; c++)
		begin
			p = (c == 7) ? 20 : (1 << c);
			wr(10'h240, c[3:0]);
			wr(10'h243, 4'h1);
			run_until(1'b1);
			check(n >= 15 * p + 6 && n <= 17 * p + 16, 1'b1);
		end
		// Charge phase changes counted over a fixed window
		wr(10'h241, 4'h1);
		wr(10'h240, 4'h6);
		for (int s = 0; s < 8; s++)
		begin
			wr(10'h20d, {s[2:0], 1'b0});
			wr(10'h243, 4'h1);
			repeat (30) @(posedge sys_clk_i);
			#1;
			t = 0;
			prev = cap_tie_vdd_o;
			repeat (96)
			begin
				@(posedge sys_clk_i);
				#1;
				if (cap_tie_vdd_o !== prev)
					t++;
				prev = cap_tie_vdd_o;
			end
			check((s == 0 || s == 7) ? t == 0 : (t >= 96 / per[s] - 1 && t <= 96 / per[s] + 1), 1'b1);
		end
		// Unused run code starts a scan like run
		wr(10'h248, 4'h2);
		run_until(1'b1);
		check(n >= 15 * 64 + 6 && n <= 17 * 64 + 16, 1'b1);
		wr(10'h248, 4'h0);
		end_of_test();
	end
endmodule : touch_pad_charge_share_detector_tb_top

// ### verif/touch_pad_far_side.sv
// Far-side model: touch electrodes and sampling capacitor on the shared pads.
// Assumes the bench commands the sensed levels while a pad switch is on.
`timescale 1ns/1ps
module touch_pad_far_side (
	input wire logic sys_clk_i,
	input wire logic [2:0] pad_switch_i,
	input wire logic schmitt_level_i,
	input wire logic comp_level_i,
	output logic schmitt_o,
	output logic comp_o
);
	logic junk_q = 1'b0;
	// Released pads hold no charge level, so a changing pattern stands in
	always @(posedge sys_clk_i)
	begin
		junk_q <= ~junk_q;
	end
	// Levels only reach the sense path while a switch joins the electrode
	assign schmitt_o = (|pad_switch_i) ? schmitt_level_i : junk_q;
	assign comp_o = (|pad_switch_i) ? comp_level_i : ~junk_q;
endmodule : touch_pad_far_side
